// ==== hw/eia_map.vh ====
`ifndef EIA_MAP_VH
`define EIA_MAP_VH
// Register word indices (byte address on the bus is index times four)
`define EIA_IDX_RISE_LO 16'hff48
`define EIA_IDX_FALL_LO 16'hff49
`define EIA_IDX_RISE_HI 16'hff4a
`define EIA_IDX_FALL_HI 16'hff4b
`define EIA_IDX_REQ 16'hff4c
`define EIA_IDX_MASK 16'hff4d
`define EIA_IDX_LEVEL 16'hff4e
`define EIA_IDX_STATUS 16'hff4f
`define EIA_IDX_SHIFT 2
`define EIA_ADDR_W 18
// Reset values
`define EIA_RST_EDGE 8'h00
`define EIA_RST_STATUS 8'h02
`define EIA_RST_MASK 10'h3ff
`define EIA_RST_LEVEL 10'h3ff
// Status word fields
`define EIA_BIT_IE 7
`define EIA_BIT_ISP 1
// Upper edge registers hold two live bits
`define EIA_HI_BITS 2
// Acceptance latency (clocks)
`define EIA_LAT_HIGH 7
`define EIA_LAT_LOW 8
`define EIA_LAT_CNT_W 4
// Core operation codes
`define EIA_OP_NONE 3'h0
`define EIA_OP_ALLOW 3'h1
`define EIA_OP_BLOCK 3'h2
`define EIA_OP_SAVE 3'h3
`define EIA_OP_LOAD 3'h4
`define EIA_OP_RETURN 3'h5
`define EIA_OP_TRAP_RET 3'h6
`define EIA_OP_W 3
// Acceptance states
`define EIA_ST_IDLE 2'h0
`define EIA_ST_WAIT 2'h1
`define EIA_ST_PUSH_SW 2'h2
`define EIA_ST_PUSH_PC 2'h3
`endif

// ==== hw/eia_ext_irq.v ====
// What this block does
// R1 - Rise/fall enable pair selects detected edge
// R2 - Edge configuration for external inputs 0..9
// R3 - Software keeps upper bits 2..7 zero
// R4 - Software clears enables before port use
// R5 - Status word resets to 02H
// R6 - Status word byte/bit access, allow/block ops; code takes them only in EIA_ST_IDLE, dropping them during an acceptance
// R7 - Save pushes, returns and load restore; code takes these ops only in EIA_ST_IDLE, dropping them during an acceptance
// R8 - Eligible when request set, mask clear
// R9 - Accepted only while accept enable set
// R10 - High handler active refuses low requests
// R11 - High level servicing after 7..32 clocks
// R12 - Low level servicing after 8..33 clocks
// R13 - Divide instruction may stretch latency
// R14 - Higher programmed level accepted first
// R15 - Same level: lowest index wins
// R16 - Refused requests stay pending
// R17 - Push status, push PC, clear enable, vector
// R18 - Level bit copied into in-service bit
// R19 - In-service bit 0 while high handler
// R20 - Level bit 0 means high priority
// R21 - Pins sampled and compared to previous
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
`include "eia_map.vh"
module eia_ext_irq #(
  parameter NPIN = 10,
  parameter PC_W = 16,
  parameter VEC_BASE = 16'h0006
) (
  input wire mclk,
  input wire reset,
  input wire clkEn,
  input wire [NPIN-1:0] extIrqPin,
  input wire [`EIA_ADDR_W-1:0] wbAdr,
  input wire [31:0] wbDatI,
  input wire [3:0] wbSel,
  input wire wbWe,
  input wire wbCyc,
  input wire wbStb,
  output reg [31:0] wbDatO,
  output reg wbAck,
  input wire [`EIA_OP_W-1:0] coreOp,
  input wire [7:0] coreStackData,
  input wire [PC_W-1:0] corePc,
  input wire coreBusy,
  output reg stackPush,
  output reg [PC_W-1:0] stackPushData,
  output reg pcLoad,
  output reg [PC_W-1:0] pcVector,
  output reg [3:0] ackIndex,
  output reg [7:0] statusWord
);
  reg [NPIN-1:0] riseEn_q;
  reg [NPIN-1:0] fallEn_q;
  reg [NPIN-1:0] pinPrev_q;
  reg [NPIN-1:0] reqFlag_q;
  reg [NPIN-1:0] maskFlag_q;
  reg [NPIN-1:0] levelSel_q;
  reg [1:0] state_q;
  reg [`EIA_LAT_CNT_W-1:0] latCnt_q;
  reg [3:0] winIdx_q;
  reg winLvl_q;
  reg [NPIN-1:0] edgeHit;
  reg [NPIN-1:0] eligible;
  reg [NPIN-1:0] candidate;
  reg [3:0] pick;
  reg pickValid;
  reg [NPIN-1:0] clrReq;
  reg [31:0] rdData;
  wire [`EIA_ADDR_W-3:0] wordIdx;
  wire wbReq;
  wire wbWr;
  wire laneWr;
  integer i;

  // Lowest-numbered set bit of a vector
  function [4:0] firstSet;
    input [NPIN-1:0] v;
    integer k;
    begin
      firstSet = 5'h00;
      for (k = NPIN - 1; k >= 0; k = k - 1) begin
        if (v[k]) begin
          firstSet = {1'b1, k[3:0]};
        end
      end
    end
  endfunction

  assign wordIdx = wbAdr[`EIA_ADDR_W-1:`EIA_IDX_SHIFT];
  assign wbReq = wbCyc && wbStb && !wbAck;
  assign wbWr = wbReq && wbWe;
  assign laneWr = wbSel[0];

  always @* begin
    edgeHit = {NPIN{1'b0}};
    for (i = 0; i < NPIN; i = i + 1) begin
      // R1 edge select decode
      // R21 compare with previous
      edgeHit[i] = (riseEn_q[i] && extIrqPin[i] && !pinPrev_q[i]) ||
                   (fallEn_q[i] && !extIrqPin[i] && pinPrev_q[i]);
    end
  end

  always @* begin
    // R8 request set, mask clear
    eligible = reqFlag_q & ~maskFlag_q;
    // R14 high level first
    // R20 level zero is high
    if ((eligible & ~levelSel_q) != {NPIN{1'b0}}) begin
      candidate = eligible & ~levelSel_q;
    end else begin
      candidate = eligible;
    end
    // R10 refuse low while high in service
    if (!statusWord[`EIA_BIT_ISP]) begin
      candidate = candidate & ~levelSel_q;
    end
    // R15 default priority by index
    {pickValid, pick} = firstSet(candidate);
  end

  always @* begin
    rdData = 32'h00000000;
    case (wordIdx)
      `EIA_IDX_RISE_LO: rdData[7:0] = riseEn_q[7:0];
      `EIA_IDX_FALL_LO: rdData[7:0] = fallEn_q[7:0];
      `EIA_IDX_RISE_HI: rdData[`EIA_HI_BITS-1:0] = riseEn_q[NPIN-1:8];
      `EIA_IDX_FALL_HI: rdData[`EIA_HI_BITS-1:0] = fallEn_q[NPIN-1:8];
      `EIA_IDX_REQ: rdData[NPIN-1:0] = reqFlag_q;
      `EIA_IDX_MASK: rdData[NPIN-1:0] = maskFlag_q;
      `EIA_IDX_LEVEL: rdData[NPIN-1:0] = levelSel_q;
      `EIA_IDX_STATUS: rdData[7:0] = statusWord;
      default: rdData = 32'h00000000;
    endcase
  end

  always @* begin
    clrReq = {NPIN{1'b0}};
    if (state_q == `EIA_ST_PUSH_SW) begin
      clrReq[winIdx_q] = 1'b1;
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      riseEn_q <= {NPIN{1'b0}};
      fallEn_q <= {NPIN{1'b0}};
      pinPrev_q <= {NPIN{1'b0}};
      reqFlag_q <= {NPIN{1'b0}};
      maskFlag_q <= `EIA_RST_MASK;
      levelSel_q <= `EIA_RST_LEVEL;
      // R5 status word reset
      statusWord <= `EIA_RST_STATUS;
      state_q <= `EIA_ST_IDLE;
      latCnt_q <= {`EIA_LAT_CNT_W{1'b0}};
      winIdx_q <= 4'h0;
      winLvl_q <= 1'b1;
      wbAck <= 1'b0;
      wbDatO <= 32'h00000000;
      stackPush <= 1'b0;
      stackPushData <= {PC_W{1'b0}};
      pcLoad <= 1'b0;
      pcVector <= {PC_W{1'b0}};
      ackIndex <= 4'h0;
    end else if (clkEn) begin
      pinPrev_q <= extIrqPin;
      wbAck <= wbReq;
      wbDatO <= wbReq ? rdData : 32'h00000000;
      stackPush <= 1'b0;
      pcLoad <= 1'b0;
      // R16 pending until accepted; set wins over clear
      reqFlag_q <= (reqFlag_q & ~clrReq) | edgeHit;
      if (wbWr && laneWr) begin
        case (wordIdx)
          // R2 ten inputs split over two pairs
          `EIA_IDX_RISE_LO: riseEn_q[7:0] <= wbDatI[7:0];
          `EIA_IDX_FALL_LO: fallEn_q[7:0] <= wbDatI[7:0];
          // R3 upper bits not stored
          `EIA_IDX_RISE_HI: riseEn_q[NPIN-1:8] <= wbDatI[`EIA_HI_BITS-1:0];
          `EIA_IDX_FALL_HI: fallEn_q[NPIN-1:8] <= wbDatI[`EIA_HI_BITS-1:0];
          `EIA_IDX_REQ: reqFlag_q <= wbDatI[NPIN-1:0] | edgeHit;
          `EIA_IDX_MASK: maskFlag_q <= wbDatI[NPIN-1:0];
          `EIA_IDX_LEVEL: levelSel_q <= wbDatI[NPIN-1:0];
          default: ;
        endcase
      end
      case (state_q)
        `EIA_ST_IDLE: begin
          // R6 byte write and core ops
          if (wbWr && laneWr && wordIdx == `EIA_IDX_STATUS) begin
            statusWord <= wbDatI[7:0];
          end else if (coreOp == `EIA_OP_ALLOW) begin
            statusWord[`EIA_BIT_IE] <= 1'b1;
          end else if (coreOp == `EIA_OP_BLOCK) begin
            statusWord[`EIA_BIT_IE] <= 1'b0;
          // R7 restore on returns and load
          end else if (coreOp == `EIA_OP_LOAD || coreOp == `EIA_OP_RETURN ||
                       coreOp == `EIA_OP_TRAP_RET) begin
            statusWord <= coreStackData;
          end else if (coreOp == `EIA_OP_SAVE) begin
            stackPush <= 1'b1;
            stackPushData <= {{(PC_W-8){1'b0}}, statusWord};
          // R9 accept enable gate
          end else if (pickValid && statusWord[`EIA_BIT_IE]) begin
            winIdx_q <= pick;
            winLvl_q <= levelSel_q[pick];
            latCnt_q <= {`EIA_LAT_CNT_W{1'b0}};
            state_q <= `EIA_ST_WAIT;
          end
        end
        `EIA_ST_WAIT: begin
          // R13 busy core stalls the count
          if (!coreBusy) begin
            latCnt_q <= latCnt_q + 1'b1;
          end
          // R11 high level latency
          // R12 low level latency
          if (!coreBusy && latCnt_q >= (winLvl_q ? `EIA_LAT_LOW - 3 : `EIA_LAT_HIGH - 3)) begin
            state_q <= `EIA_ST_PUSH_SW;
          end
        end
        `EIA_ST_PUSH_SW: begin
          // R17 push status first
          stackPush <= 1'b1;
          stackPushData <= {{(PC_W-8){1'b0}}, statusWord};
          statusWord[`EIA_BIT_IE] <= 1'b0;
          // R18 R19 copy level into in-service
          statusWord[`EIA_BIT_ISP] <= winLvl_q;
          state_q <= `EIA_ST_PUSH_PC;
        end
        `EIA_ST_PUSH_PC: begin
          // R17 push PC and load vector in the same cycle
          stackPush <= 1'b1;
          stackPushData <= corePc;
          pcLoad <= 1'b1;
          pcVector <= VEC_BASE + {{(PC_W-5){1'b0}}, winIdx_q, 1'b0};
          ackIndex <= winIdx_q;
          state_q <= `EIA_ST_IDLE;
        end
        default: state_q <= `EIA_ST_IDLE;
      endcase
    end
  end
endmodule // eia_ext_irq

// ==== verif/eia_ext_irq_asserts.sv ====
`timescale 1ns/1ps
module eia_ext_irq_asserts #(
  parameter PC_W = 16,
  parameter VEC_BASE = 16'h0006
) (
  input wire mclk,
  input wire reset,
  input wire clkEn,
  input wire wbCyc,
  input wire wbStb,
  input wire wbAck,
  input wire stackPush,
  input wire [PC_W-1:0] stackPushData,
  input wire pcLoad,
  input wire [PC_W-1:0] pcVector,
  input wire [3:0] ackIndex,
  input wire [7:0] statusWord
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Accept steps: status push, then PC push with vector
  sequence pushSw; stackPush && !pcLoad; endsequence
  sequence pushPc; stackPush && pcLoad; endsequence
  ack_follow_a: assert property (wbCyc && wbStb && !wbAck && clkEn |=> wbAck)
    else $error("ack missing");
  ack_pulse_a: assert property (wbAck && clkEn |=> !wbAck)
    else $error("ack too long");
  accept_seq_a: assert property (pushSw ##1 pushPc |=> !stackPush && !pcLoad)
    else $error("push order wrong");
  pc_order_a: assert property (pcLoad |-> $past(stackPush) && !$past(pcLoad))
    else $error("pc pushed before status");
  ie_clear_a: assert property (pcLoad |-> !statusWord[7])
    else $error("enable not cleared");
  ie_gate_a: assert property ($rose(pcLoad) |-> $past(statusWord[7], 2))
    else $error("accept while disabled");
  sw_data_a: assert property ($rose(stackPush) |-> stackPushData == $past(statusWord))
    else $error("status push data wrong");
  vector_a: assert property (pcLoad |-> pcVector == VEC_BASE + 2 * ackIndex)
    else $error("vector wrong");
  reset_sw_a: assert property ($fell(reset) |-> statusWord == 8'h02)
    else $error("status reset value wrong");
endmodule // eia_ext_irq_asserts

bind eia_ext_irq eia_ext_irq_asserts #(.PC_W(PC_W), .VEC_BASE(VEC_BASE)) eia_ext_irq_asserts_i (
  .mclk(mclk), .reset(reset), .clkEn(clkEn), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck),
  .stackPush(stackPush), .stackPushData(stackPushData), .pcLoad(pcLoad),
  .pcVector(pcVector), .ackIndex(ackIndex), .statusWord(statusWord));

// ==== verif/eia_pin_model.sv ====
`timescale 1ns/1ps
module eia_pin_model (
  input wire [9:0] pinSet,
  input wire busySet,
  output wire [9:0] extIrqPin,
  output wire [7:0] coreStackData,
  output wire [15:0] corePc,
  output wire coreBusy
);
  // Pins follow the levels asked for
  assign extIrqPin = pinSet;
  // Idle core with a status byte on its stack
  assign coreStackData = 8'h80;
  assign corePc = 16'h1234;
  // Divide in progress while the bench asks for it
  assign coreBusy = busySet;
endmodule // eia_pin_model

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`include "eia_map.vh"
module testbench;
  logic mclk = 0, reset = 1, clkEn = 1, wbWe = 0, wbCyc = 0, wbStb = 0;
  logic [17:0] wbAdr = 0;
  logic [31:0] wbDatI = 0;
  logic [3:0] wbSel = 4'hf, lastIdx;
  logic [2:0] coreOp = 0;
  logic [9:0] pinSet = 0, r;
  logic busy = 0;
  integer busyLen = 0;
  wire [31:0] wbDatO;
  wire [15:0] stackPushData, pcVector, corePc;
  wire [9:0] extIrqPin;
  wire [7:0] statusWord, coreStackData;
  wire [3:0] ackIndex;
  wire wbAck, stackPush, pcLoad, coreBusy;
  integer mismatches = 0, nTests = 0, cyc = 0, m;
  eia_pin_model eia_pin_model_i (.pinSet(pinSet), .busySet(busy), .extIrqPin(extIrqPin),
    .coreStackData(coreStackData), .corePc(corePc), .coreBusy(coreBusy));
  eia_ext_irq eia_ext_irq_i (.mclk(mclk), .reset(reset), .clkEn(clkEn), .extIrqPin(extIrqPin),
    .wbAdr(wbAdr), .wbDatI(wbDatI), .wbSel(wbSel), .wbWe(wbWe), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbDatO(wbDatO), .wbAck(wbAck), .coreOp(coreOp), .coreStackData(coreStackData),
    .corePc(corePc), .coreBusy(coreBusy), .stackPush(stackPush),
    .stackPushData(stackPushData), .pcLoad(pcLoad), .pcVector(pcVector),
    .ackIndex(ackIndex), .statusWord(statusWord));
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin
      mismatches++;
      conclude;
    end
  end
  task conclude;
    $display("tests %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task ck(input logic [31:0] e, s, input string n);
    nTests++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task wb(input logic we, input logic [15:0] a, input logic [9:0] d, output logic [9:0] q);
    wbCyc <= 1;
    wbStb <= 1;
    wbWe <= we;
    wbAdr <= {a, 2'b00};
    wbDatI <= {22'h0, d};
    do @(posedge mclk); while (wbAck !== 1'b1);
    q = wbDatO[9:0];
    wbCyc <= 0;
    wbStb <= 0;
    @(posedge mclk);
  endtask
  // Set status, move pins, count accepts over 40 clocks
  task hit(input logic [9:0] p, input logic [7:0] s, input integer ne, lo, hi);
    integer i, n, l;
    n = 0;
    l = 0;
    wb(1, `EIA_IDX_STATUS, {2'b0, s}, r);
    pinSet <= p;
    for (i = 1; i <= 40; i++) begin
      @(posedge mclk);
      busy <= (i < busyLen);
      if (pcLoad === 1'b1) begin
        n++;
        l = i - 1;
        lastIdx = ackIndex;
      end
    end
    ck(ne, n, "accept count");
    if (ne > 0) ck(1, l >= lo && l <= hi, "latency");
  endtask
  task t_regs;
    for (m = 0; m < 4; m++) begin
      wb(0, `EIA_IDX_RISE_LO + m, 0, r);
      ck(0, r, "edge reset");
    end
    wb(0, `EIA_IDX_STATUS, 0, r);
    ck(8'h02, r, "status reset");
    wb(1, `EIA_IDX_FALL_HI, 10'h3ff, r);
    wb(0, `EIA_IDX_FALL_HI, 0, r);
    ck(10'h003, r, "upper bits");
    wb(1, `EIA_IDX_FALL_HI, 0, r);
    wb(0, 16'hff50, 0, r);
    ck(0, r, "unmapped read");
    $display("done regs");
  endtask
  task t_edge;
    wb(1, `EIA_IDX_MASK, 10'h3fe, r);
    wb(1, `EIA_IDX_LEVEL, 10'h3fe, r);
    for (m = 0; m < 4; m++) begin
      wb(1, `EIA_IDX_RISE_LO, {9'h0, m[1]}, r);
      wb(1, `EIA_IDX_FALL_LO, {9'h0, m[0]}, r);
      hit(10'h001, 8'h82, m[1], 7, 32);
      hit(10'h000, 8'h82, m[0], 7, 32);
    end
    wb(1, `EIA_IDX_LEVEL, 10'h3ff, r);
    hit(10'h001, 8'h82, 1, 8, 33);
    busyLen = 20;
    hit(10'h000, 8'h82, 1, 20, 99);
    busyLen = 0;
    wb(1, `EIA_IDX_RISE_LO, 0, r);
    wb(1, `EIA_IDX_FALL_LO, 0, r);
    hit(10'h000, 8'h82, 0, 0, 0);
    $display("done edges");
  endtask
  task t_prio;
    wb(1, `EIA_IDX_RISE_LO, 10'h03c, r);
    wb(1, `EIA_IDX_MASK, 10'h3c3, r);
    wb(1, `EIA_IDX_LEVEL, 10'h3df, r);
    hit(10'h028, 8'h82, 1, 7, 32);
    ck(5, lastIdx, "high level first");
    ck(0, statusWord[1], "service bit high");
    ck(16'h0010, pcVector, "vector pin five");
    ck(16'h1234, stackPushData, "pushed pc");
    hit(10'h028, 8'h80, 0, 0, 0);
    hit(10'h028, 8'h82, 1, 0, 99);
    ck(3, lastIdx, "pending accepted");
    ck(16'h000c, pcVector, "vector pin three");
    ck(1, statusWord[1], "service bit low");
    wb(1, `EIA_IDX_LEVEL, 10'h3c3, r);
    hit(10'h03c, 8'h02, 0, 0, 0);
    hit(10'h03c, 8'h82, 1, 0, 99);
    ck(2, lastIdx, "default order");
    $display("done priority");
  endtask
  task t_ops;
    logic [10:0] tbl [7] = '{{`EIA_OP_ALLOW, 8'h82}, {`EIA_OP_BLOCK, 8'h02},
      {`EIA_OP_LOAD, 8'h80}, {`EIA_OP_BLOCK, 8'h00}, {`EIA_OP_RETURN, 8'h80},
      {`EIA_OP_BLOCK, 8'h00}, {`EIA_OP_TRAP_RET, 8'h80}};
    wb(1, `EIA_IDX_MASK, 10'h3ff, r);
    wb(1, `EIA_IDX_STATUS, 10'h002, r);
    for (m = 0; m < 7; m++) begin
      coreOp <= tbl[m][10:8];
      @(posedge mclk);
      coreOp <= `EIA_OP_NONE;
      @(posedge mclk);
      ck(tbl[m][7:0], statusWord, "status after op");
    end
    wb(0, `EIA_IDX_STATUS, 0, r);
    ck(8'h80, r, "status read");
    clkEn <= 0;
    coreOp <= `EIA_OP_BLOCK;
    @(posedge mclk);
    @(posedge mclk);
    ck(8'h80, statusWord, "frozen status");
    clkEn <= 1;
    coreOp <= `EIA_OP_SAVE;
    @(posedge mclk);
    coreOp <= `EIA_OP_NONE;
    @(posedge mclk);
    ck(1, stackPush, "save push");
    ck(16'h0080, stackPushData, "saved status");
    @(posedge mclk);
    $display("done ops");
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 0;
    @(posedge mclk);
    t_regs;
    t_edge;
    t_prio;
    t_ops;
    conclude;
  end
endmodule // testbench
